// ==== hw/atr_defines.svh ====
// Offsets, field positions and reset values of the task-file register bank.
// Assumes an 8-bit register port with a 4-bit offset, as decoded by the host front end.
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH

`define ATR_OFF_SECCNT      4'h2
`define ATR_OFF_SECTOR      4'h3
`define ATR_OFF_CYL_LO      4'h4
`define ATR_OFF_CYL_HI      4'h5
`define ATR_OFF_CARD_HEAD   4'h6
`define ATR_OFF_STATE       4'h7
`define ATR_OFF_SHADOW_CTL  4'hE
`define ATR_OFF_DRIVE_VIEW  4'hF
`define ATR_OFF_ERROR       4'h1

`define ATR_CH_LBA_BIT      6
`define ATR_CH_CARD_BIT     4
`define ATR_CTL_SRST_BIT    2
`define ATR_CTL_IDIS_BIT    1
`define ATR_ERR_ABORTED_COMMAND_FLAG_BIT    2

`define ATR_CARD_HEAD_RST   8'hA0
`define ATR_BYTE_RST        8'h00
`define ATR_UNMAPPED_READ   8'hFF

`endif

// ==== hw/atr_pkg.sv ====
// Types shared by the task-file register bank.
// Assumes the defines header is compiled alongside.
package atr_pkg;

  typedef struct packed {
    logic       busy;
    logic       ready;
    logic       write_fault_flag;
    logic       seek_complete_flag;
    logic       data_request_flag;
    logic       corrected_error_flag;
    logic       index_flag;
    logic       error;
  } atr_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } atr_req_t;

  typedef struct packed {
    logic       busy;
    logic       ready;
    logic       write_fault;
    logic       data_request;
    logic       corrected;
    logic       error;
    logic       abort;
    logic       done;
    logic       write_active;
    logic       sector_dec;
    logic       dma_want;
  } atr_core_t;

  typedef enum logic [1:0] {
    ATR_RUN,
    ATR_SOFT_RESET
  } atr_mode_t;

endpackage

// ==== hw/atr_task_file.sv ====
// Task-file register bank: address registers, status views, device control and drive view.
// Assumes one-cycle read/write strobes synchronous to clk, and a core that reports state.
`timescale 1ns/1ns
`include "atr_defines.svh"

module atr_task_file
  import atr_pkg::*;
#(
  parameter logic CARD_ID = 1'b0
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire atr_req_t   host_req,
  input  wire atr_core_t  core,
  output logic [7:0]      host_rdata,
  output logic            host_irq,
  output logic            dma_request,
  output logic            soft_reset,
  output logic            lba_mode,
  output logic [27:0]     target_address,
  output logic            card_selected,
  output logic [7:0]      sector_count
);

  logic [7:0]  sector_ff;
  logic [7:0]  cyl_lo_ff;
  logic [7:0]  cyl_hi_ff;
  logic [7:0]  card_head_ff;
  logic [7:0]  seccnt_ff;
  logic        srst_ff;
  logic        irq_dis_ff;
  logic        abort_ff;
  logic        irq_ff;
  logic        drq_prev_ff;
  logic        dma_ff;
  logic [7:0]  rdata_ff;
  logic        lba_ff;
  logic [27:0] addr_ff;
  logic        sel_ff;
  atr_state_t  state_now;
  atr_mode_t   mode_ff;
  logic        addr_wr_ok;
  logic        irq_event;
  logic        primary_read;
  logic [7:0]  nxt_rdata;
  logic [7:0]  drive_view;
  logic [7:0]  error_view;
  logic        take_sector;
  logic        take_cyl_lo;
  logic        take_cyl_hi;
  logic        take_card_head;
  logic        take_seccnt;
  logic        take_ctl;

  function automatic logic hit_wr(input atr_req_t r, input logic [3:0] off);
    hit_wr = r.wr && (r.addr == off);
  endfunction

  // Soft reset clears command state like a hardware reset but keeps the address registers.
  function automatic logic in_reset(input logic r, input atr_mode_t m);
    in_reset = r || (m == ATR_SOFT_RESET);
  endfunction

  // Busy blanks every other status bit, since none of them is valid meanwhile.
  always_comb
  begin
    state_now                      = '0;
    state_now.busy                 = core.busy;
    if (!core.busy)
    begin
      state_now.ready                = core.ready && (mode_ff == ATR_RUN);
      state_now.write_fault_flag     = core.write_fault;
      state_now.seek_complete_flag   = core.ready;
      state_now.data_request_flag    = core.data_request;
      state_now.corrected_error_flag = core.corrected;
      state_now.index_flag           = 1'b0;
      state_now.error                = core.error;
    end
  end

  assign addr_wr_ok   = !core.busy && (mode_ff == ATR_RUN);
  assign primary_read = host_req.rd && (host_req.addr == `ATR_OFF_STATE);
  assign irq_event    = core.done || (core.data_request && !drq_prev_ff);

  // A refused write is dropped silently; the host learns of it only by reading back.
  assign take_sector    = addr_wr_ok && hit_wr(host_req, `ATR_OFF_SECTOR);
  assign take_cyl_lo    = addr_wr_ok && hit_wr(host_req, `ATR_OFF_CYL_LO);
  assign take_cyl_hi    = addr_wr_ok && hit_wr(host_req, `ATR_OFF_CYL_HI);
  assign take_card_head = addr_wr_ok && hit_wr(host_req, `ATR_OFF_CARD_HEAD);
  assign take_seccnt    = addr_wr_ok && hit_wr(host_req, `ATR_OFF_SECCNT);
  assign take_ctl       = hit_wr(host_req, `ATR_OFF_SHADOW_CTL);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sector_ff <= `ATR_BYTE_RST;
    end
    else if (take_sector)
    begin
      sector_ff <= host_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cyl_lo_ff <= `ATR_BYTE_RST;
    end
    else if (take_cyl_lo)
    begin
      cyl_lo_ff <= host_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cyl_hi_ff <= `ATR_BYTE_RST;
    end
    else if (take_cyl_hi)
    begin
      cyl_hi_ff <= host_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      card_head_ff <= `ATR_CARD_HEAD_RST;
    end
    else if (take_card_head)
    begin
      // Bits 7 and 5 are stored as written; nothing here depends on them.
      card_head_ff <= host_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    // Zero stands for 256 sectors, so a decrement from zero leaves 255 to go.
    if (rst)
    begin
      seccnt_ff <= `ATR_BYTE_RST;
    end
    else if (take_seccnt)
    begin
      seccnt_ff <= host_req.wdata;
    end
    else if (core.sector_dec)
    begin
      seccnt_ff <= seccnt_ff - 8'h01;
    end
  end

  // Control is written regardless of busy so a hung command can be reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      srst_ff <= 1'b0;
    end
    else if (take_ctl)
    begin
      srst_ff <= host_req.wdata[`ATR_CTL_SRST_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_dis_ff <= 1'b0;
    end
    else if (take_ctl)
    begin
      irq_dis_ff <= host_req.wdata[`ATR_CTL_IDIS_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_ff <= ATR_RUN;
    end
    else if (take_ctl)
    begin
      mode_ff <= host_req.wdata[`ATR_CTL_SRST_BIT] ? ATR_SOFT_RESET : ATR_RUN;
    end
  end

  // Error abort flag: a new abort beats a clearing completion in the same cycle.
  always_ff @(posedge clk)
  begin
    if (in_reset(rst, mode_ff))
    begin
      abort_ff <= 1'b0;
    end
    else if (core.abort)
    begin
      abort_ff <= 1'b1;
    end
    else if (core.done)
    begin
      abort_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (in_reset(rst, mode_ff))
    begin
      drq_prev_ff <= 1'b0;
    end
    else
    begin
      drq_prev_ff <= core.data_request;
    end
  end

  // An event while interrupts are disabled is dropped, not held for later.
  always_ff @(posedge clk)
  begin
    if (in_reset(rst, mode_ff))
    begin
      irq_ff <= 1'b0;
    end
    else if (irq_event && !irq_dis_ff)
    begin
      irq_ff <= 1'b1;
    end
    else if (primary_read)
    begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (in_reset(rst, mode_ff))
    begin
      dma_ff <= 1'b0;
    end
    else
    begin
      dma_ff <= core.dma_want && (core.busy || core.data_request);
    end
  end

  // These views lag the registers by one clock, so the core must not use them on a write.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lba_ff <= 1'b0;
    end
    else
    begin
      lba_ff <= card_head_ff[`ATR_CH_LBA_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_ff <= '0;
    end
    else
    begin
      addr_ff <= {card_head_ff[3:0], cyl_hi_ff, cyl_lo_ff, sector_ff};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_ff <= 1'b0;
    end
    else
    begin
      sel_ff <= card_head_ff[`ATR_CH_CARD_BIT] == CARD_ID;
    end
  end

  // Bit 7 is left at zero; a shared floppy controller may own it.
  always_comb
  begin
    drive_view      = 8'h00;
    drive_view[6]   = !core.write_active;
    drive_view[5:2] = ~card_head_ff[3:0];
    drive_view[1]   = !(sel_ff && card_head_ff[`ATR_CH_CARD_BIT]);
    drive_view[0]   = !(sel_ff && !card_head_ff[`ATR_CH_CARD_BIT]);
  end

  always_comb
  begin
    error_view                    = 8'h00;
    error_view[`ATR_ERR_ABORTED_COMMAND_FLAG_BIT] = abort_ff;
  end

  always_comb
  begin
    nxt_rdata = `ATR_UNMAPPED_READ;
    unique case (host_req.addr)
      `ATR_OFF_ERROR:      nxt_rdata = error_view;
      `ATR_OFF_SECCNT:     nxt_rdata = seccnt_ff;
      `ATR_OFF_SECTOR:     nxt_rdata = sector_ff;
      `ATR_OFF_CYL_LO:     nxt_rdata = cyl_lo_ff;
      `ATR_OFF_CYL_HI:     nxt_rdata = cyl_hi_ff;
      `ATR_OFF_CARD_HEAD:  nxt_rdata = card_head_ff;
      `ATR_OFF_STATE,
      `ATR_OFF_SHADOW_CTL: nxt_rdata = state_now;
      `ATR_OFF_DRIVE_VIEW: nxt_rdata = drive_view;
      default:             nxt_rdata = `ATR_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    // Read data holds between reads so a slow host may sample it late.
    if (rst)
    begin
      rdata_ff <= `ATR_BYTE_RST;
    end
    else if (host_req.rd)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign host_rdata     = rdata_ff;
  assign host_irq       = irq_ff;
  assign dma_request    = dma_ff;
  assign soft_reset     = srst_ff;
  assign lba_mode       = lba_ff;
  assign target_address = addr_ff;
  assign card_selected  = sel_ff;
  assign sector_count   = seccnt_ff;

endmodule

// ==== tb/atr_asserts.sv ====
// Port checker for the task-file bank.
// Assumes it is bound onto atr_task_file.
`timescale 1ns/1ns
module atr_asserts
  import atr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire atr_req_t    host_req,
  input wire atr_core_t   core,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_irq,
  input wire logic        dma_request,
  input wire logic        soft_reset,
  input wire logic        lba_mode,
  input wire logic [27:0] target_address
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire rd7 = host_req.rd && host_req.addr == 4'h7;
  wire rde = host_req.rd && host_req.addr == 4'hE;
  wire wok = host_req.wr && !core.busy && !soft_reset;
  chk_index_reads_zero: assert property ((rd7 || rde) |=> !host_rdata[1])
    else $error("index bit not zero");
  chk_busy_hides_state: assert property (rd7 && core.busy |=> host_rdata == 8'h80)
    else $error("busy status wrong");
  chk_dma_gated: assert property (dma_request |-> $past(core.busy || core.data_request))
    else $error("dma without busy or drq");
  chk_ctl_always_taken: assert property (
    host_req.wr && host_req.addr == 4'hE |=> soft_reset == $past(host_req.wdata[2]))
    else $error("soft reset not taken");
  chk_alt_keeps_irq: assert property (rde && host_irq |=> host_irq)
    else $error("alt read cleared irq");
  chk_lba_flag_copy: assert property (
    wok && host_req.addr == 4'h6 |=> ##1 lba_mode == $past(host_req.wdata[6], 2))
    else $error("lba flag wrong");
  chk_busy_write_refused: assert property (
    host_req.wr && host_req.addr == 4'h3 && core.busy ##1 !host_req.wr |=> $stable(target_address))
    else $error("write taken while busy");
  chk_sector_to_addr: assert property (
    wok && host_req.addr == 4'h3 |=> ##1 target_address[7:0] == $past(host_req.wdata, 2))
    else $error("sector not in address");
  cover property (rd7 && host_irq);
  cover property (dma_request);
  cover property (soft_reset);
endmodule

bind atr_task_file atr_asserts atr_asserts_i (.clk(clk), .rst(rst), .host_req(host_req),
  .core(core), .host_rdata(host_rdata), .host_irq(host_irq), .dma_request(dma_request),
  .soft_reset(soft_reset), .lba_mode(lba_mode), .target_address(target_address));

// ==== tb/atr_core_model.sv ====
// Small command core: busy, then a data phase, then a done pulse.
// Assumes start is a one-cycle pulse; flt makes the command fail.
`timescale 1ns/1ns
module atr_core_model
  import atr_pkg::*;
(
  input  wire logic start,
  input  wire logic flt,
  input  wire logic clk,
  input  wire logic rst,
  output atr_core_t core
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      core   <= '0;
    end
    else
    begin
      cnt_ff <= start ? 4'h9 : cnt_ff - {3'h0, cnt_ff != 4'h0};
      core.ready <= 1'b1;
      core.busy <= start || cnt_ff > 4'h3;
      core.write_active <= start || cnt_ff > 4'h3;
      core.data_request <= cnt_ff inside {4'h2, 4'h3};
      core.dma_want <= cnt_ff inside {4'h2, 4'h3};
      core.done <= cnt_ff == 4'h1;
      core.sector_dec <= cnt_ff == 4'h2;
      core.abort <= flt && cnt_ff == 4'h1;
      // Fault levels follow flt every cycle, not the command, so they persist after done.
      core.write_fault <= flt;
      core.corrected <= flt;
      core.error <= flt;
    end
  end
endmodule

// ==== tb/tb_ata_task_file_registers.sv ====
// Self-checking bench for the task-file bank with a core model.
// Assumes package, design, model and checker compile first.
`timescale 1ns/1ns
module tb_ata_task_file_registers;
  import atr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        flt = 1'b0;
  atr_req_t    req = '0;
  atr_core_t   core;
  logic [7:0]  rdata;
  logic [7:0]  scnt;
  logic [27:0] taddr;
  logic        irq, dma, srst, lba, sel;
  int          error_cnt = 0;
  int          n_tests = 0;
  always #50 clk = ~clk;
  atr_core_model atr_core_model_i (.clk(clk), .rst(rst), .start(start), .flt(flt), .core(core));
  atr_task_file atr_task_file_i (.clk(clk), .rst(rst), .host_req(req), .core(core),
    .host_rdata(rdata), .host_irq(irq), .dma_request(dma), .soft_reset(srst), .lba_mode(lba),
    .target_address(taddr), .card_selected(sel), .sector_count(scnt));
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk) req <= {a, ~w, w, d};
    @(posedge clk) req <= '0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk(rdata, e);
  endtask
  task automatic cmd(input logic f);
    @(posedge clk);
    start <= 1'b1;
    flt <= f;
    @(posedge clk) start <= 1'b0;
  endtask
  task automatic wait_done;
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 40 && core.done !== 1'b1; i++)
    begin
      if (dma === 1'b1)
        seen = 1'b1;
      @(negedge clk);
    end
    if (i == 40)
    begin
      chk(1'b0, 1'b1);
      complete_run;
    end
    chk(seen, 1'b1);
    repeat (2) @(negedge clk);
  endtask
  task automatic s_reset;
    rc(4'h6, 8'hA0);
    rc(4'hF, 8'h7E);
    rc(4'h9, 8'hFF);
  endtask
  task automatic s_addr;
    acc(4'h3, 1'b1, 8'h11);
    acc(4'h4, 1'b1, 8'h22);
    acc(4'h5, 1'b1, 8'h33);
    acc(4'h6, 1'b1, 8'hE5);
    chk(taddr, 28'h5332211);
    chk({lba, sel}, 2'b11);
    rc(4'h4, 8'h22);
    rc(4'hF, 8'h6A);
    acc(4'h6, 1'b1, 8'hB5);
    chk({lba, sel}, 2'b00);
  endtask
  task automatic s_cmd;
    acc(4'hE, 1'b1, 8'h00);
    acc(4'h2, 1'b1, 8'h03);
    cmd(1'b0);
    acc(4'h3, 1'b1, 8'hFF);
    rc(4'h7, 8'h80);
    wait_done;
    chk(taddr, 28'h5332211);
    chk(irq, 1'b1);
    rc(4'h2, 8'h02);
    chk(scnt, 8'h02);
    rc(4'h1, 8'h00);
    rc(4'hE, 8'h50);
    chk(irq, 1'b1);
    rc(4'h7, 8'h50);
    chk(irq, 1'b0);
  endtask
  task automatic s_srst;
    acc(4'hE, 1'b1, 8'h04);
    chk(srst, 1'b1);
    acc(4'h7, 1'b0, 8'h00);
    chk(rdata[6], 1'b0);
    acc(4'hE, 1'b1, 8'hFA);
    chk(srst, 1'b0);
    cmd(1'b1);
    wait_done;
    chk(irq, 1'b0);
    rc(4'h7, 8'h75);
    rc(4'h1, 8'h04);
  endtask
  task automatic complete_run;
    $display("Mismatches %0d in %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    s_reset;
    s_addr;
    s_cmd;
    s_srst;
    complete_run;
  end
endmodule
